// ===== pkg/dcsw_pkg.sv
// package for the drive command/state word block: bit positions, reset values,
// field structs and the reversing source encoding.
// assumes a single 40 MHz clock and synchronous active-low reset.
package dcsw_pkg;

  // command word bit positions
  localparam int CMD_PRESET_LO   = 0;
  localparam int CMD_DC_BRAKE_N  = 2;
  localparam int CMD_COAST_N     = 3;
  localparam int CMD_QSTOP_N     = 4;
  localparam int CMD_HOLD_N      = 5;
  localparam int CMD_RUN         = 6;
  localparam int CMD_RESET       = 7;
  localparam int CMD_JOG         = 8;
  localparam int CMD_RAMP2       = 9;
  localparam int CMD_VALID       = 10;
  localparam int CMD_RELAY_A     = 11;
  localparam int CMD_RELAY_B     = 12;
  localparam int CMD_SETUP_LO    = 13;
  localparam int CMD_REVERSE     = 15;

  // state word bit positions
  localparam int ST_CTRL_READY   = 0;
  localparam int ST_DRIVE_READY  = 1;
  localparam int ST_ENABLE       = 2;
  localparam int ST_TRIP         = 3;
  localparam int ST_ERROR        = 4;
  localparam int ST_RESERVED     = 5;
  localparam int ST_TRIPLOCK     = 6;
  localparam int ST_WARNING      = 7;
  localparam int ST_AT_REF       = 8;
  localparam int ST_BUS_CTRL     = 9;
  localparam int ST_IN_LIMIT     = 10;
  localparam int ST_RUNNING      = 11;
  localparam int ST_OVERTEMP     = 12;
  localparam int ST_VOLTAGE      = 13;
  localparam int ST_TORQUE       = 14;
  localparam int ST_TIMER        = 15;

  // reset values: safe command is all stop requests active (bits zero)
  localparam logic [15:0] CMD_RESET_VALUE   = 16'h0000;
  localparam logic [15:0] STATE_RESET_VALUE = 16'h0000;

  // reversing source selection
  typedef enum logic [1:0] {REV_DIGITAL, REV_SERIAL, REV_LOGIC_OR, REV_LOGIC_AND} dcsw_rev_src_t;

  // decoded command fields
  typedef struct packed {
    logic [1:0] presetSel;
    logic       dcBrake;
    logic       coast;
    logic       quickStop;
    logic       holdFreq;
    logic       rampStop;
    logic       jog;
    logic       rampSet2;
    logic [1:0] setupSel;
    logic       reverse;
  } dcsw_cmd_t;

  // drive condition inputs feeding the state word
  typedef struct packed {
    logic ctrlReady;
    logic tripped;
    logic errorNoTrip;
    logic tripLocked;
    logic warning;
    logic atReference;
    logic localStop;
    logic localRefSite;
    logic inSpeedLimits;
    logic startPresent;
    logic outputNonZero;
    logic overTempStop;
    logic dcLinkFault;
    logic currentLimit;
    logic thermalTimer;
    logic coastActive;
  } dcsw_cond_t;

endpackage

// ===== rtl/dcsw_edge_detect.sv
// rising edge detector with registered pulse output.
// assumes input synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module dcsw_edge_detect
(
  input  wire logic clock,   // system clock
  input  wire logic nrst,    // sync reset, active low
  input  wire logic enable,  // sample qualifier
  input  wire logic level,   // watched level
  output var  logic pulse    // one cycle on 0 to 1
);
  logic prev;
  logic next_prev;
  logic next_pulse;

  // hold the old level when not sampled, so no false edge appears
  always_comb
  begin
    next_prev  = enable ? level : prev;
    next_pulse = enable & level & ~prev;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      prev  <= 1'b0;
      pulse <= 1'b0;
    end
    else
    begin
      prev  <= next_prev;
      pulse <= next_pulse;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/dcsw_core.sv
// command word decode and state word assembly for a drive bus profile.
// assumes telegram framing elsewhere delivers a word with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - bits 1:0 pick one of four presets
// - bit 2 low gives DC brake stop
// - bit 3 low coasts output stage off
// - bit 4 low ramps down quick-stop
// - bit 5 low freezes output frequency
// - frozen drive stops only by coast/brake/digital stop
// - bit 6 low ramps down to stop
// - trip reset only on bit 7 rise
// - bit 8 selects jog speed reference
// - bit 10 low means ignore word
// - bits 11/12 drive configured relays
// - bits 14:13 select set-up if enabled
// - bit 15 reverses if source allows
// - status 0 ready, 1 ready-but-coasting
// - status 3,4,6,7 trip, error, lock, warning
// - status 5 always zero
// - status 8 speed equals reference
// - status 9 bus control possible
// - status 10 in limits, 11 running
// - status 12-15 temp, voltage, current, timer
// - link lost forces state word zero
module dcsw_core
  import dcsw_pkg::*;
(
  input  wire logic          clock,          // 40 MHz system clock
  input  wire logic          nrst,           // sync reset, active low
  input  wire logic [15:0]   cmdWord,        // received command word
  input  wire logic          cmdStrobe,      // new telegram present
  input  wire logic          relayAFollow,   // relay A follows bit 11
  input  wire logic          relayBFollow,   // relay B follows bit 12
  input  wire logic          multiSetup,     // multi set-up enabled
  input  wire dcsw_rev_src_t revSource,      // reversing source
  input  wire logic          revInput,       // digital reverse input
  input  wire logic          diStop,         // digital DC brake/coast stop
  input  wire dcsw_cond_t    cond,           // drive conditions
  input  wire logic          linkLost,       // fieldbus link or comm fault
  output logic [1:0]         presetSel,      // preset reference index
  output logic               dcBrake,        // DC brake and stop
  output logic               coast,          // output stage off
  output logic               quickStop,      // quick-stop ramp down
  output logic               holdFreq,       // freeze output frequency
  output logic               rampStop,       // ramp down to stop
  output logic               allowStart,     // all start conditions held
  output logic               jog,            // jog speed reference
  output logic               rampSet2,       // second ramp pair
  output logic               tripReset,      // one-cycle trip clear
  output logic               relayA,         // relay A drive
  output logic               relayB,         // relay B drive
  output logic [1:0]         setupSel,       // active set-up index
  output logic               reverse,        // reverse rotation
  output logic [15:0]        driveStateWord  // reported state word
);

  logic [15:0] cmd;         // drive_command_word, last accepted
  logic [15:0] next_cmd;
  logic        cmdFresh;    // accepted word this cycle, feeds edge detect
  logic        next_cmdFresh;
  logic        resetPulse;
  logic [1:0]  setupHeld;
  dcsw_cmd_t   dec;
  dcsw_cmd_t   next_dec;
  logic        next_allowStart;
  logic        next_relayA;
  logic        next_relayB;
  logic [1:0]  next_setup;
  logic        next_reverse;
  logic [15:0] next_state;

  // capture only valid telegrams; others leave the old word in force
  always_comb
  begin
    next_cmd      = cmd;
    next_cmdFresh = 1'b0;
    if (cmdStrobe && cmdWord[CMD_VALID])
    begin
      next_cmd      = cmdWord;
      next_cmdFresh = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      cmd      <= CMD_RESET_VALUE;
      cmdFresh <= 1'b0;
    end
    else
    begin
      cmd      <= next_cmd;
      cmdFresh <= next_cmdFresh;
    end
  end

  // reset edge is judged across accepted words only, so an ignored word cannot fake a rise
  dcsw_edge_detect u_reset_edge
  (
    .clock  (clock),
    .nrst   (nrst),
    .enable (cmdFresh),
    .level  (cmd[CMD_RESET]),
    .pulse  (resetPulse)
  );

  // field decode; stop bits are active low in the word
  always_comb
  begin
    next_dec.presetSel = cmd[CMD_PRESET_LO +: 2];
    next_dec.dcBrake   = ~cmd[CMD_DC_BRAKE_N];
    next_dec.coast     = ~cmd[CMD_COAST_N];
    next_dec.quickStop = ~cmd[CMD_QSTOP_N];
    next_dec.holdFreq  = ~cmd[CMD_HOLD_N];
    next_dec.rampStop  = ~cmd[CMD_RUN];
    next_dec.jog       = cmd[CMD_JOG];
    next_dec.rampSet2  = cmd[CMD_RAMP2];
    next_dec.setupSel  = cmd[CMD_SETUP_LO +: 2];
    next_dec.reverse   = cmd[CMD_REVERSE];
    // while frozen, only coast, DC brake or a digital stop may halt the drive
    if (next_dec.holdFreq)
      next_allowStart = ~(next_dec.coast | next_dec.dcBrake | diStop);
    else
      next_allowStart = ~(next_dec.coast | next_dec.dcBrake | diStop
                          | next_dec.quickStop | next_dec.rampStop);
    next_relayA  = relayAFollow & cmd[CMD_RELAY_A];
    next_relayB  = relayBFollow & cmd[CMD_RELAY_B];
    next_setup   = multiSetup ? cmd[CMD_SETUP_LO +: 2] : setupHeld;
    unique case (revSource)
      REV_DIGITAL:   next_reverse = revInput;
      REV_SERIAL:    next_reverse = cmd[CMD_REVERSE];
      REV_LOGIC_OR:  next_reverse = revInput | cmd[CMD_REVERSE];
      REV_LOGIC_AND: next_reverse = revInput & cmd[CMD_REVERSE];
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      dec        <= '0;
      allowStart <= 1'b0;
      relayA     <= 1'b0;
      relayB     <= 1'b0;
      setupHeld  <= 2'h0;
      reverse    <= 1'b0;
    end
    else
    begin
      dec        <= next_dec;
      allowStart <= next_allowStart;
      relayA     <= next_relayA;
      relayB     <= next_relayB;
      setupHeld  <= next_setup;
      reverse    <= next_reverse;
    end
  end

  // output aliases straight from decode flops
  assign presetSel = dec.presetSel;
  assign dcBrake   = dec.dcBrake;
  assign coast     = dec.coast;
  assign quickStop = dec.quickStop;
  assign holdFreq  = dec.holdFreq;
  assign rampStop  = dec.rampStop;
  assign jog       = dec.jog;
  assign rampSet2  = dec.rampSet2;
  assign setupSel  = setupHeld;
  assign tripReset = resetPulse;

  // state word assembly; a lost link blanks every bit
  always_comb
  begin
    next_state                 = STATE_RESET_VALUE;
    next_state[ST_CTRL_READY]  = cond.ctrlReady & ~cond.tripped;
    next_state[ST_DRIVE_READY] = cond.ctrlReady & ~cond.tripped & cond.coastActive;
    next_state[ST_ENABLE]      = ~cond.coastActive;
    next_state[ST_TRIP]        = cond.tripped;
    next_state[ST_ERROR]       = cond.errorNoTrip;
    next_state[ST_RESERVED]    = 1'b0;
    next_state[ST_TRIPLOCK]    = cond.tripLocked;
    next_state[ST_WARNING]     = cond.warning;
    next_state[ST_AT_REF]      = cond.atReference;
    next_state[ST_BUS_CTRL]    = ~(cond.localStop | cond.localRefSite);
    next_state[ST_IN_LIMIT]    = cond.inSpeedLimits;
    next_state[ST_RUNNING]     = cond.startPresent | cond.outputNonZero;
    next_state[ST_OVERTEMP]    = cond.overTempStop;
    next_state[ST_VOLTAGE]     = cond.dcLinkFault;
    next_state[ST_TORQUE]      = cond.currentLimit;
    next_state[ST_TIMER]       = cond.thermalTimer;
    if (linkLost)
      next_state = STATE_RESET_VALUE;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      driveStateWord <= STATE_RESET_VALUE;
    else
      driveStateWord <= next_state;
  end

  // checks
  property p_invalid_ignored;
    @(posedge clock) disable iff (!nrst)
    (cmdStrobe && !cmdWord[CMD_VALID]) |=> cmd == $past(cmd);
  endproperty
  a_invalid_ignored: assert property (p_invalid_ignored) else $error("invalid word changed command");

  property p_valid_taken;
    @(posedge clock) disable iff (!nrst)
    (cmdStrobe && cmdWord[CMD_VALID]) |=> cmd == $past(cmdWord);
  endproperty
  a_valid_taken: assert property (p_valid_taken) else $error("valid word not taken");

  property p_reset_edge;
    @(posedge clock) disable iff (!nrst)
    tripReset |-> cmd[CMD_RESET] && !$past(cmd[CMD_RESET], 2);
  endproperty
  a_reset_edge: assert property (p_reset_edge) else $error("trip reset without rising edge");

  property p_coast;
    @(posedge clock) disable iff (!nrst)
    !cmd[CMD_COAST_N] |=> coast && !allowStart;
  endproperty
  a_coast: assert property (p_coast) else $error("coast not applied");

  property p_brake;
    @(posedge clock) disable iff (!nrst)
    !cmd[CMD_DC_BRAKE_N] |=> dcBrake && !allowStart;
  endproperty
  a_brake: assert property (p_brake) else $error("dc brake not applied");

  property p_preset;
    @(posedge clock) disable iff (!nrst)
    ##1 presetSel == $past(cmd[1:0]);
  endproperty
  a_preset: assert property (p_preset) else $error("preset index wrong");

  property p_relay;
    @(posedge clock) disable iff (!nrst)
    (!relayAFollow || !cmd[CMD_RELAY_A]) |=> !relayA;
  endproperty
  a_relay: assert property (p_relay) else $error("relay A energised wrongly");

  property p_link_lost;
    @(posedge clock) disable iff (!nrst)
    linkLost |=> driveStateWord == 16'h0000;
  endproperty
  a_link_lost: assert property (p_link_lost) else $error("state word not blanked");

  property p_reserved;
    @(posedge clock) disable iff (!nrst)
    !driveStateWord[ST_RESERVED];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_trip_ready;
    @(posedge clock) disable iff (!nrst)
    (cond.tripped && !linkLost) |=> driveStateWord[ST_TRIP] && !driveStateWord[ST_CTRL_READY];
  endproperty
  a_trip_ready: assert property (p_trip_ready) else $error("trip status wrong");

  property p_setup_hold;
    @(posedge clock) disable iff (!nrst)
    !multiSetup |=> $stable(setupSel);
  endproperty
  a_setup_hold: assert property (p_setup_hold) else $error("set-up changed while single");

  // stop requests, selects and state bits one cycle after their cause
  property p_quick_stop;
    @(posedge clock) disable iff (!nrst)
    !cmd[CMD_QSTOP_N] |=> quickStop;
  endproperty
  a_quick_stop: assert property (p_quick_stop) else $error("quick stop not applied");

  property p_hold_start;
    @(posedge clock) disable iff (!nrst)
    (!cmd[CMD_HOLD_N] && cmd[CMD_DC_BRAKE_N] && cmd[CMD_COAST_N] && !diStop) |=> allowStart;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("frozen drive stopped wrongly");

  property p_ramp_stop;
    @(posedge clock) disable iff (!nrst)
    (cmd[CMD_HOLD_N] && !cmd[CMD_RUN]) |=> rampStop && !allowStart;
  endproperty
  a_ramp_stop: assert property (p_ramp_stop) else $error("ramp stop not applied");

  property p_jog;
    @(posedge clock) disable iff (!nrst)
    ##1 jog == $past(cmd[CMD_JOG]);
  endproperty
  a_jog: assert property (p_jog) else $error("jog select wrong");

  property p_ramp_set;
    @(posedge clock) disable iff (!nrst)
    ##1 rampSet2 == $past(cmd[CMD_RAMP2]);
  endproperty
  a_ramp_set: assert property (p_ramp_set) else $error("ramp pair select wrong");

  property p_reverse_serial;
    @(posedge clock) disable iff (!nrst)
    (revSource == REV_SERIAL) |=> reverse == $past(cmd[CMD_REVERSE]);
  endproperty
  a_reverse_serial: assert property (p_reverse_serial) else $error("serial reverse wrong");

  property p_running;
    @(posedge clock) disable iff (!nrst)
    (!linkLost && (cond.startPresent || cond.outputNonZero)) |=> driveStateWord[ST_RUNNING];
  endproperty
  a_running: assert property (p_running) else $error("running bit not set");

  property p_bus_ctrl;
    @(posedge clock) disable iff (!nrst)
    cond.localStop |=> !driveStateWord[ST_BUS_CTRL];
  endproperty
  a_bus_ctrl: assert property (p_bus_ctrl) else $error("bus control shown in local stop");

endmodule
`default_nettype wire

// ===== dv/dcsw_master_model.sv
// bus master model: delivers command telegrams to the drive block.
// assumes send is called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module dcsw_master_model
(
  input  wire logic        clock,     // system clock
  output logic      [15:0] cmdWord,   // command word lines
  output logic             cmdStrobe  // one-cycle telegram mark
);
  // idle lines at time zero
  initial
  begin
    cmdWord = 16'h0000;
    cmdStrobe = 1'b0;
  end

  // one telegram held for one edge; afterwards the data is inverted so a
  // stale word never looks like a fresh one to the block
  task automatic send(input logic [15:0] w, input logic valid);
    cmdWord <= valid ? (w | 16'h0400) : (w & 16'hfbff);
    cmdStrobe <= 1'b1;
    @(posedge clock);
    cmdStrobe <= 1'b0;
    cmdWord <= ~w;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_drive_control_status_word.sv
// self-checking bench for the command decode and state word block.
// assumes the master model sends telegrams; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module tb_drive_control_status_word;
  import dcsw_pkg::*;
  logic          clock, nrst, relayAFollow, relayBFollow, multiSetup;
  logic          revInput, diStop, linkLost, cmdStrobe;
  logic          dcBrake, coast, quickStop, holdFreq, rampStop, allowStart;
  logic          jog, rampSet2, tripReset, relayA, relayB, reverse;
  logic [1:0]    presetSel, setupSel;
  logic [15:0]   cmdWord, driveStateWord;
  dcsw_rev_src_t revSource;
  dcsw_cond_t    cond;
  int            errors, checksDone;
  logic [15:0]   tbl [4] = '{16'h0400, 16'h0565, 16'h047e, 16'h073b};

  dcsw_master_model i_dcsw_master_model (.clock(clock), .cmdWord(cmdWord), .cmdStrobe(cmdStrobe));
  dcsw_core i_dcsw_core (.clock(clock), .nrst(nrst), .cmdWord(cmdWord), .cmdStrobe(cmdStrobe),
    .relayAFollow(relayAFollow), .relayBFollow(relayBFollow), .multiSetup(multiSetup),
    .revSource(revSource), .revInput(revInput), .diStop(diStop), .cond(cond), .linkLost(linkLost),
    .presetSel(presetSel), .dcBrake(dcBrake), .coast(coast), .quickStop(quickStop),
    .holdFreq(holdFreq), .rampStop(rampStop), .allowStart(allowStart), .jog(jog),
    .rampSet2(rampSet2), .tripReset(tripReset), .relayA(relayA), .relayB(relayB),
    .setupSel(setupSel), .reverse(reverse), .driveStateWord(driveStateWord));

  // 40 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check16({15'h0000, got}, {15'h0000, exp});
  endtask

  // expected decode, independent of the design
  function automatic logic [15:0] dec(input logic [15:0] w);
    dec = {7'h00, w[1:0], ~w[2], ~w[3], ~w[4], ~w[5], ~w[6], w[8], w[9]};
  endfunction

  function automatic logic [15:0] st(input dcsw_cond_t c);
    logic rdy;
    rdy = c.ctrlReady & ~c.tripped;
    st = {c.thermalTimer, c.currentLimit, c.dcLinkFault, c.overTempStop,
          c.startPresent | c.outputNonZero, c.inSpeedLimits, ~(c.localStop | c.localRefSite),
          c.atReference, c.warning, c.tripLocked, 1'b0, c.errorNoTrip, c.tripped,
          ~c.coastActive, rdy & c.coastActive, rdy};
  endfunction

  function automatic logic [15:0] outs();
    outs = {7'h00, presetSel, dcBrake, coast, quickStop, holdFreq, rampStop, jog, rampSet2};
  endfunction

  // telegram then wait for decoded outputs two edges after it is taken
  task automatic tx(input logic [15:0] w, input logic valid);
    @(posedge clock);
    i_dcsw_master_model.send(w, valid);
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic test_decode;
    for (int i = 0; i < 4; i++)
    begin
      tx(tbl[i], 1'b1);
      check16(outs(), dec(tbl[i]));
    end
    tx(16'h0000, 1'b0);
    check16(outs(), dec(tbl[3]));
    $display("test decode done");
  endtask

  // pulse stands only in the cycle after the word is stored, so look there
  task automatic trip(input logic [15:0] w, input logic valid, input logic exp);
    @(posedge clock);
    i_dcsw_master_model.send(w, valid);
    @(posedge clock);
    #1;
    check1(tripReset, exp);
    @(posedge clock);
    #1;
    check1(tripReset, 1'b0);
  endtask

  task automatic test_trip;
    trip(16'h0480, 1'b1, 1'b1);
    trip(16'h0480, 1'b1, 1'b0);
    trip(16'h0400, 1'b1, 1'b0);
    trip(16'h0480, 1'b0, 1'b0);
    trip(16'h0480, 1'b1, 1'b1);
    $display("test trip done");
  endtask

  task automatic test_relay_setup;
    tx(16'h1c00, 1'b1);
    check16(16'({relayA, relayB}), 16'h0000);
    @(posedge clock);
    relayAFollow <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check16(16'({relayA, relayB}), 16'h0002);
    @(posedge clock);
    multiSetup <= 1'b1;
    relayBFollow <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      tx(16'h1400 | (16'(s) << 13), 1'b1);
      check16(16'({setupSel, relayA, relayB}), 16'(s << 2) | 16'h0001);
    end
    @(posedge clock);
    multiSetup <= 1'b0;
    tx(16'h0400, 1'b1);
    check16(16'(setupSel), 16'h0003);
    $display("test relay and setup done");
  endtask

  task automatic test_reverse;
    logic exp;
    tx(16'h8400, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      revSource <= dcsw_rev_src_t'(i >> 1);
      revInput <= i[0];
      repeat (2) @(posedge clock);
      #1;
      exp = (i >> 1) == 0 ? i[0] : ((i >> 1) == 3 ? i[0] : 1'b1);
      check1(reverse, exp);
    end
    tx(16'h0400, 1'b1);
    check1(reverse, 1'b0);
    $display("test reverse done");
  endtask

  task automatic test_start;
    @(posedge clock);
    cond <= dcsw_cond_t'(16'h8000); // controls ready, nothing else
    tx(16'h040c, 1'b1);
    check1(allowStart, 1'b1);
    @(posedge clock);
    diStop <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check1(allowStart, 1'b0);
    @(posedge clock);
    diStop <= 1'b0;
    tx(16'h042c, 1'b1);
    check1(allowStart, 1'b0);
    tx(16'h0474, 1'b1);
    check1(allowStart, 1'b0);
    tx(16'h047c, 1'b1);
    check1(allowStart, 1'b1);
    $display("test start done");
  endtask

  task automatic test_state;
    dcsw_cond_t c;
    for (int k = 0; k < 18; k++)
    begin
      c = k < 16 ? dcsw_cond_t'(16'h0001 << k) : dcsw_cond_t'(16'hffff);
      @(posedge clock);
      cond <= c;
      linkLost <= (k == 17);
      @(posedge clock);
      #1;
      check16(driveStateWord, k == 17 ? 16'h0000 : st(c));
    end
    $display("test state done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial
  begin
    repeat (3000) @(posedge clock);
    errors++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    errors = 0;
    checksDone = 0;
    nrst = 1'b0;
    {relayAFollow, relayBFollow, multiSetup, revInput, diStop, linkLost} = '0;
    revSource = REV_DIGITAL;
    cond = '0;
    repeat (6) @(posedge clock);
    #1;
    check16(driveStateWord, 16'h0000);
    @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check16(outs(), dec(16'h0000));
    test_decode();
    test_trip();
    test_relay_setup();
    test_reverse();
    test_start();
    test_state();
    report_and_stop();
  end
endmodule
`default_nettype wire
